// ===== src/hk_pkg.sv
package hk_pkg;

	//////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int NUM_AXES     = 3;
	localparam int DET_PER_AXIS = 3;
	localparam int NUM_DET      = NUM_AXES * DET_PER_AXIS;
	localparam int NUM_THERM    = 5;
	localparam int NUM_ANALOG   = 8;
	localparam int ANALOG_W     = 7;
	localparam int WORD_W       = 10;
	localparam int SUB_W        = 4;
	localparam int SEL_W        = 3;
	localparam int DIV_W        = 7;

	//////////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned CLK_HZ      = 10_000_000;
	localparam int unsigned FLIP_EXC_HZ = 90_000;
	localparam int unsigned GRAV_EXC_HZ = 95_000;
	localparam logic [DIV_W-1:0] FLIP_HALF_CYC = DIV_W'(CLK_HZ / (2 * FLIP_EXC_HZ));
	localparam logic [DIV_W-1:0] GRAV_HALF_CYC = DIV_W'(CLK_HZ / (2 * GRAV_EXC_HZ));
	localparam logic [DIV_W-1:0] DIV_ONE       = 7'h01;

	//////////////////////////////////////////////////////////////////////////
	// frame
	localparam logic [SUB_W-1:0] HK_WORD_POS = 4'h5;
	localparam logic [SUB_W-1:0] WORD_FIRST  = 4'h1;
	localparam logic [SUB_W-1:0] WORD_LAST   = 4'hf;
	localparam logic [SUB_W-1:0] SUB_LAST    = 4'hf;
	localparam logic [SUB_W-1:0] SUB_ONE     = 4'h1;
	localparam logic [SEL_W-1:0] SEL_ONE     = 3'h1;
	localparam logic [SEL_W-1:0] SEL_REF     = 3'h7;

	//////////////////////////////////////////////////////////////////////////
	// flip position codes
	localparam logic [1:0] FLIP_NONE = 2'h0;
	localparam logic [1:0] FLIP_0    = 2'h1;
	localparam logic [1:0] FLIP_90   = 2'h2;
	localparam logic [1:0] FLIP_180  = 2'h3;

	//////////////////////////////////////////////////////////////////////////
	// registers
	localparam logic [7:0] ADDR_CMD    = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_HKWORD = 8'h08;

	typedef struct packed {
		logic       temp_ctrl;
		logic       heater;
		logic       oper_mode;
		logic       filter_bypass;
		logic       cal_inhibit;
		logic [8:0] offset;
		logic [1:0] offset_addr;
		logic [1:0] meas_range;
	} cmd_s;

	localparam int   CMD_W     = $bits(cmd_s);
	localparam cmd_s CMD_RESET = '0;

	// detectors: bit0 = 0 deg, bit1 = 90 deg, bit2 = 180 deg
	function automatic logic [1:0] encode_flip(input logic [DET_PER_AXIS-1:0] d);
		logic [1:0] code;
		code = FLIP_NONE;
		unique case (d)
			3'h1:    code = FLIP_0;
			3'h2:    code = FLIP_90;
			3'h4:    code = FLIP_180;
			default: code = FLIP_NONE;
		endcase
		return code;
	endfunction

	function automatic logic addr_ok(input logic [7:0] a, input logic wr);
		return (a == ADDR_CMD) || (!wr && (a == ADDR_STATUS || a == ADDR_HKWORD));
	endfunction

endpackage

// ===== src/hk_status_if.sv
interface hk_status_if;
	logic [5:0] flip_pos;
	logic [2:0] gimbal;

	modport src (output flip_pos, gimbal);
	modport dst (input flip_pos, gimbal);
endinterface

// ===== src/position_encoder.sv
module position_encoder
	import hk_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [8:0]  det_pins,
	input  wire logic [2:0]  gimbal_open_pins,
	hk_status_if.src         st
);

	localparam int NPIN = NUM_DET + NUM_AXES;

	logic [NPIN-1:0] pins;
	logic [NPIN-1:0] sync1_ff;
	logic [NPIN-1:0] sync2_ff;
	logic [5:0]      flip_ff;
	logic [5:0]      nxt_flip;
	logic [2:0]      gim_ff;
	logic [2:0]      nxt_gim;

	//////////////////////////////////////////////////////////////////////////
	// two-stage synchronisers for detector and switch pins
	assign pins = {gimbal_open_pins, det_pins};

	genvar g;
	generate
		for (g = 0; g < NPIN; g++) begin : g_sync
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					sync1_ff[g] <= 1'b0;
					sync2_ff[g] <= 1'b0;
				end else begin
					sync1_ff[g] <= pins[g]; // [R3]
					sync2_ff[g] <= sync1_ff[g];
				end
			end
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// encode three detectors per head, pass gimbal contacts
	always_comb begin
		for (int a = 0; a < NUM_AXES; a++) begin
			nxt_flip[2*a +: 2] = encode_flip(sync2_ff[DET_PER_AXIS*a +: DET_PER_AXIS]); // [R1] [R2]
		end
		nxt_gim = sync2_ff[NPIN-1:NUM_DET]; // [R4] [R5]
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flip_ff <= '0;
			gim_ff  <= '0;
		end else begin
			flip_ff <= nxt_flip;
			gim_ff  <= nxt_gim;
		end
	end

	assign st.flip_pos = flip_ff;
	assign st.gimbal   = gim_ff;

	//////////////////////////////////////////////////////////////////////////
	// checks
	property p_flip_zero;
		@(posedge clk) disable iff (!rst_n)
		det_pins[2:0] == 3'h1 [*3] |=> flip_ff[1:0] == FLIP_0;
	endproperty
	a_flip_zero: assert property (p_flip_zero) else $error("flip 0 deg not encoded"); // [R2]

	property p_flip_fault;
		@(posedge clk) disable iff (!rst_n)
		det_pins[5:3] == 3'h0 [*3] |=> flip_ff[3:2] == FLIP_NONE;
	endproperty
	a_flip_fault: assert property (p_flip_fault) else $error("missing position not false"); // [R1]

	property p_gimbal_open;
		@(posedge clk) disable iff (!rst_n)
		gimbal_open_pins[0] [*3] |=> gim_ff[0];
	endproperty
	a_gimbal_open: assert property (p_gimbal_open) else $error("open switch not reported 1"); // [R5]

	property p_gimbal_closed;
		@(posedge clk) disable iff (!rst_n)
		!gimbal_open_pins[2] [*3] |=> !gim_ff[2];
	endproperty
	a_gimbal_closed: assert property (p_gimbal_closed) else $error("closed switch not 0"); // [R4]

endmodule

// ===== src/housekeeping_status_encoder.sv
// Overview of operation
// [R1] report each sensor's flip position as its own 2-bit word, three words
// [R2] three detectors per head encode into that head's 2-bit position word
// [R3] nine detector channels excite a capacitor with square wave, return one level
// [R4] report gimbal state of each sensor as one status bit, three bits
// [R5] gimbal bit is 1 when switch open (pre), 0 when closed (post)
// [R6] pulse reference excitation onto each of five thermistor networks for conversion
// [R7] two gravity-level channels excited by precision square wave, level to converter
// [R8] reference supply given as housekeeping channel at 7-bit resolution
// [R9] command state reports range, offset address, offset, cal inhibit, filter state
// [R10] filter bypass command is accepted and shown in the filter status
// [R11] housekeeping goes in frame word 5; every frame word is 10 bits
// [R12] housekeeping word time-shares eight analog signals plus two status bits per slot
// [R13] status inputs synchronised and held stable while a word is assembled
// [R14] subframe channel steps once per host frame, wrapping after the last
module housekeeping_status_encoder
	import hk_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [8:0]  det_pins,
	input  wire logic [2:0]  gimbal_open_pins,
	input  wire logic        frame_sync_pin,
	input  wire logic        word_tick_pin,
	input  wire logic [6:0]  conv_data,
	input  wire logic        conv_valid,
	output logic      [2:0]  conv_sel,
	output logic             flip_exc,
	output logic             grav_exc,
	output logic      [4:0]  therm_exc,
	output logic      [9:0]  hk_word,
	output logic             hk_valid,
	output logic      [3:0]  subframe
);

	hk_status_if st ();

	logic [1:0]          tsync1_ff;
	logic [1:0]          tsync2_ff;
	logic [1:0]          tsync3_ff;
	logic                frame_edge;
	logic                word_edge;

	logic [DIV_W-1:0]    fdiv_ff;
	logic [DIV_W-1:0]    nxt_fdiv;
	logic [DIV_W-1:0]    gdiv_ff;
	logic [DIV_W-1:0]    nxt_gdiv;
	logic                flip_exc_ff;
	logic                nxt_flip_exc;
	logic                grav_exc_ff;
	logic                nxt_grav_exc;

	logic [SEL_W-1:0]    conv_sel_ff;
	logic [SEL_W-1:0]    nxt_conv_sel;
	logic [ANALOG_W-1:0] analog_ff [NUM_ANALOG];
	logic [ANALOG_W-1:0] nxt_analog [NUM_ANALOG];
	logic [4:0]          therm_exc_ff;
	logic [4:0]          nxt_therm_exc;

	logic [SUB_W-1:0]    subframe_ff;
	logic [SUB_W-1:0]    nxt_subframe;
	logic [SUB_W-1:0]    word_idx_ff;
	logic [SUB_W-1:0]    nxt_word_idx;
	logic [WORD_W-1:0]   hk_asm_ff;
	logic [WORD_W-1:0]   nxt_hk_asm;
	logic [WORD_W-1:0]   hk_word_ff;
	logic [WORD_W-1:0]   nxt_hk_word;
	logic                hk_valid_ff;
	logic                nxt_hk_valid;
	logic [1:0]          flags;

	cmd_s                cmd_ff;
	cmd_s                nxt_cmd;
	logic [31:0]         prdata_ff;
	logic [31:0]         nxt_prdata;
	logic                pready_ff;
	logic                nxt_pready;
	logic                pslverr_ff;
	logic                nxt_pslverr;
	logic                setup;

	//////////////////////////////////////////////////////////////////////////
	// flip and gimbal position encoding
	position_encoder u_pos (
		.clk              (pclk),
		.rst_n            (presetn),
		.det_pins         (det_pins),
		.gimbal_open_pins (gimbal_open_pins),
		.st               (st)
	);

	//////////////////////////////////////////////////////////////////////////
	// host timing pins: frame start and word tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tsync1_ff <= '0;
			tsync2_ff <= '0;
			tsync3_ff <= '0;
		end else begin
			tsync1_ff <= {word_tick_pin, frame_sync_pin};
			tsync2_ff <= tsync1_ff;
			tsync3_ff <= tsync2_ff;
		end
	end

	assign frame_edge = tsync2_ff[0] & ~tsync3_ff[0];
	assign word_edge  = tsync2_ff[1] & ~tsync3_ff[1];

	//////////////////////////////////////////////////////////////////////////
	// excitation dividers
	always_comb begin
		nxt_fdiv     = fdiv_ff + DIV_ONE;
		nxt_flip_exc = flip_exc_ff;
		if (fdiv_ff == FLIP_HALF_CYC - DIV_ONE) begin
			nxt_fdiv     = '0;
			nxt_flip_exc = ~flip_exc_ff; // [R3]
		end
		nxt_gdiv     = gdiv_ff + DIV_ONE;
		nxt_grav_exc = grav_exc_ff;
		if (gdiv_ff == GRAV_HALF_CYC - DIV_ONE) begin
			nxt_gdiv     = '0;
			nxt_grav_exc = ~grav_exc_ff; // [R7]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fdiv_ff     <= '0;
			gdiv_ff     <= '0;
			flip_exc_ff <= 1'b0;
			grav_exc_ff <= 1'b0;
		end else begin
			fdiv_ff     <= nxt_fdiv;
			gdiv_ff     <= nxt_gdiv;
			flip_exc_ff <= nxt_flip_exc;
			grav_exc_ff <= nxt_grav_exc;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// converter channel scan and analog store
	always_comb begin
		nxt_conv_sel = conv_sel_ff;
		for (int i = 0; i < NUM_ANALOG; i++) begin
			nxt_analog[i] = analog_ff[i];
		end
		if (conv_valid) begin
			nxt_analog[conv_sel_ff] = conv_data; // [R8]
			nxt_conv_sel            = conv_sel_ff + SEL_ONE;
		end
		for (int t = 0; t < NUM_THERM; t++) begin
			nxt_therm_exc[t] = (nxt_conv_sel == SEL_W'(t)); // [R6]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_sel_ff  <= '0;
			therm_exc_ff <= '0;
			for (int i = 0; i < NUM_ANALOG; i++) begin
				analog_ff[i] <= '0;
			end
		end else begin
			conv_sel_ff  <= nxt_conv_sel;
			therm_exc_ff <= nxt_therm_exc;
			for (int i = 0; i < NUM_ANALOG; i++) begin
				analog_ff[i] <= nxt_analog[i];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// status flag pair for the next subframe
	always_comb begin
		unique case (nxt_subframe) // [R9] [R12]
			4'h0:    flags = st.flip_pos[1:0];
			4'h1:    flags = st.flip_pos[3:2];
			4'h2:    flags = st.flip_pos[5:4];
			4'h3:    flags = {st.gimbal[0], st.gimbal[1]}; // [R4]
			4'h4:    flags = {st.gimbal[2], cmd_ff.temp_ctrl};
			4'h5:    flags = {1'b1, cmd_ff.heater};
			4'h6:    flags = cmd_ff.meas_range;
			4'h7:    flags = 2'h3;
			4'h8:    flags = cmd_ff.offset[1:0];
			4'h9:    flags = cmd_ff.offset[3:2];
			4'ha:    flags = cmd_ff.offset[5:4];
			4'hb:    flags = cmd_ff.offset[7:6];
			4'hc:    flags = {cmd_ff.offset[8], cmd_ff.oper_mode};
			4'hd:    flags = cmd_ff.offset_addr;
			4'he:    flags = {~cmd_ff.filter_bypass, cmd_ff.cal_inhibit}; // [R10]
			default: flags = 2'h0;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// frame sequencing and word assembly
	always_comb begin
		nxt_subframe = subframe_ff;
		nxt_word_idx = word_idx_ff;
		nxt_hk_asm   = hk_asm_ff;
		nxt_hk_word  = hk_word_ff;
		nxt_hk_valid = 1'b0;
		if (frame_edge) begin
			nxt_subframe = subframe_ff + SUB_ONE; // [R14]
			nxt_word_idx = WORD_FIRST;
			nxt_hk_asm   = {analog_ff[nxt_subframe[SEL_W-1:0]], flags, 1'b0}; // [R12] [R13]
		end else if (word_edge && word_idx_ff != WORD_LAST) begin
			nxt_word_idx = word_idx_ff + SUB_ONE;
		end
		if ((frame_edge || word_edge) && nxt_word_idx == HK_WORD_POS) begin
			nxt_hk_word  = hk_asm_ff; // [R11]
			if (frame_edge) begin
				nxt_hk_word = nxt_hk_asm;
			end
			nxt_hk_valid = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			subframe_ff <= SUB_LAST;
			word_idx_ff <= '0;
			hk_asm_ff   <= '0;
			hk_word_ff  <= '0;
			hk_valid_ff <= 1'b0;
		end else begin
			subframe_ff <= nxt_subframe;
			word_idx_ff <= nxt_word_idx;
			hk_asm_ff   <= nxt_hk_asm;
			hk_word_ff  <= nxt_hk_word;
			hk_valid_ff <= nxt_hk_valid;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// apb slave
	assign setup = psel & ~penable;

	always_comb begin
		nxt_cmd     = cmd_ff;
		nxt_pready  = setup;
		nxt_pslverr = setup & ~addr_ok(paddr, pwrite);
		nxt_prdata  = '0;
		if (setup && !pwrite) begin
			unique case (paddr)
				ADDR_CMD:    nxt_prdata = 32'(cmd_ff);
				ADDR_STATUS: nxt_prdata = 32'({subframe_ff, st.gimbal, st.flip_pos});
				ADDR_HKWORD: nxt_prdata = 32'(hk_word_ff);
				default:     nxt_prdata = '0;
			endcase
		end
		if (psel && penable && pready_ff && pwrite && !pslverr_ff) begin
			nxt_cmd = cmd_s'(pwdata[CMD_W-1:0]); // [R9] [R10]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_ff     <= CMD_RESET;
			prdata_ff  <= '0;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			cmd_ff     <= nxt_cmd;
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata    = prdata_ff;
	assign pready    = pready_ff;
	assign pslverr   = pslverr_ff;
	assign conv_sel  = conv_sel_ff;
	assign flip_exc  = flip_exc_ff;
	assign grav_exc  = grav_exc_ff;
	assign therm_exc = therm_exc_ff;
	assign hk_word   = hk_word_ff;
	assign hk_valid  = hk_valid_ff;
	assign subframe  = subframe_ff;

	//////////////////////////////////////////////////////////////////////////
	// checks
	property p_flip_exc;
		@(posedge pclk) disable iff (!presetn)
		$changed(flip_exc_ff) |-> $past(fdiv_ff) == FLIP_HALF_CYC - DIV_ONE;
	endproperty
	a_flip_exc: assert property (p_flip_exc) else $error("flip excitation half period wrong"); // [R3]

	property p_grav_exc;
		@(posedge pclk) disable iff (!presetn)
		$changed(grav_exc_ff) |-> $past(gdiv_ff) == GRAV_HALF_CYC - DIV_ONE;
	endproperty
	a_grav_exc: assert property (p_grav_exc) else $error("level excitation half period wrong"); // [R7]

	property p_therm;
		@(posedge pclk) disable iff (!presetn)
		conv_sel_ff == 3'h2 |-> therm_exc_ff == 5'h04;
	endproperty
	a_therm: assert property (p_therm) else $error("thermistor pulse not on selected channel"); // [R6]

	property p_ref_store;
		@(posedge pclk) disable iff (!presetn)
		conv_valid && conv_sel_ff == SEL_REF |=> analog_ff[SEL_REF] == $past(conv_data);
	endproperty
	a_ref_store: assert property (p_ref_store) else $error("reference sample not stored"); // [R8]

	sequence s_frame;
		frame_edge;
	endsequence

	property p_sub_step;
		@(posedge pclk) disable iff (!presetn)
		s_frame |=> subframe_ff == $past(subframe_ff) + SUB_ONE;
	endproperty
	a_sub_step: assert property (p_sub_step) else $error("subframe did not step"); // [R14]

	property p_hk_pos;
		@(posedge pclk) disable iff (!presetn)
		hk_valid_ff |-> word_idx_ff == HK_WORD_POS;
	endproperty
	a_hk_pos: assert property (p_hk_pos) else $error("housekeeping word outside slot 5"); // [R11]

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		$changed(hk_word_ff) |-> hk_valid_ff;
	endproperty
	a_hold: assert property (p_hold) else $error("housekeeping word changed mid frame"); // [R13]

	property p_filter;
		@(posedge pclk) disable iff (!presetn)
		s_frame ##0 (subframe_ff == 4'hd) |=> hk_asm_ff[2] == !$past(cmd_ff.filter_bypass);
	endproperty
	a_filter: assert property (p_filter) else $error("filter status not bypass inverse"); // [R10]

endmodule

// ===== tb/host_model.sv
module host_model
	import hk_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic [9:0]  hk_word,
	input  wire logic        hk_valid,
	output logic             frame_sync_pin,
	output logic             word_tick_pin,
	output logic      [9:0]  last_word,
	output int               n_words
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		frame_sync_pin = 1'b0;
		word_tick_pin  = 1'b0;
		last_word      = '0;
		n_words        = 0;
	end

	//////////////////////////////////////////////////////////////////////////
	// sampling of the presented word
	always @(posedge pclk) begin
		if (hk_valid === 1'b1) begin
			last_word <= hk_word;
			n_words   <= n_words + 1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// pulses high and low three cycles each
	task automatic pulse(input logic sync);
		if (sync)
			frame_sync_pin <= 1'b1;
		else
			word_tick_pin <= 1'b1;
		repeat (3) @(posedge pclk);
		frame_sync_pin <= 1'b0;
		word_tick_pin  <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask

	// frame start, then word ticks up to the housekeeping word
	task automatic run_frame();
		@(posedge pclk);
		pulse(1'b1);
		repeat (HK_WORD_POS - WORD_FIRST) pulse(1'b0);
		repeat (6) @(posedge pclk);
	endtask
endmodule

// ===== tb/tb.sv
module tb
	import hk_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [8:0]  det_pins;
	logic [2:0]  gimbal_open_pins, conv_sel;
	logic        frame_sync_pin, word_tick_pin, conv_valid, flip_exc, grav_exc, hk_valid;
	logic [6:0]  conv_data;
	logic [4:0]  therm_exc;
	logic [9:0]  hk_word, last_word, lw;
	logic [3:0]  subframe;
	int          n_fail, n_checks, n_words, seed;
	logic [33:0] qa[$];
	logic [13:0] qh[$];
	logic [6:0]  ana[8];

	housekeeping_status_encoder dut_u (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.det_pins(det_pins), .gimbal_open_pins(gimbal_open_pins),
		.frame_sync_pin(frame_sync_pin), .word_tick_pin(word_tick_pin),
		.conv_data(conv_data), .conv_valid(conv_valid), .conv_sel(conv_sel),
		.flip_exc(flip_exc), .grav_exc(grav_exc), .therm_exc(therm_exc),
		.hk_word(hk_word), .hk_valid(hk_valid), .subframe(subframe)
	);

	host_model host_u (
		.pclk(pclk), .hk_word(hk_word), .hk_valid(hk_valid), .frame_sync_pin(frame_sync_pin),
		.word_tick_pin(word_tick_pin), .last_word(last_word), .n_words(n_words)
	);

	always #50 pclk = ~pclk;

	//////////////////////////////////////////////////////////////////////////
	// reporting
	task automatic bad(input string m);
		n_fail++;
		$display("wrong value at %0t: %s", $time, m);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic cmp_bus(input logic [33:0] e);
		n_checks++;
		if (pslverr !== e[32] || (e[33] && prdata !== e[31:0]))
			bad($sformatf("apb err %b data %h exp %h", pslverr, prdata, e));
	endtask

	task automatic cmp_hk(input logic [13:0] e);
		n_checks++;
		if ({subframe, hk_word} !== e)
			bad($sformatf("word %h sub %h exp %h", hk_word, subframe, e));
	endtask

	task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp)
			bad($sformatf("%s got %h exp %h", m, got, exp));
	endtask

	//////////////////////////////////////////////////////////////////////////
	// expected status coding
	function automatic logic [1:0] fc(input logic [2:0] d);
		case (d)
			3'h1:    return 2'h1;
			3'h2:    return 2'h2;
			3'h4:    return 2'h3;
			default: return 2'h0;
		endcase
	endfunction

	function automatic logic [1:0] flg(input int k, input logic [8:0] d, input logic [2:0] g,
		input cmd_s c);
		case (k)
			0, 1, 2: return fc(d[3*k+:3]);
			3:       return {g[0], g[1]};
			4:       return {g[2], c.temp_ctrl};
			5:       return {1'b1, c.heater};
			6:       return c.meas_range;
			7:       return 2'h3;
			12:      return {c.offset[8], c.oper_mode};
			13:      return c.offset_addr;
			14:      return {~c.filter_bypass, c.cal_inhibit};
			15:      return 2'h0;
			default: return c.offset[2*(k-8)+:2];
		endcase
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// apb master and monitor
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [33:0] e);
		int i;
		qa.push_back(e);
		@(posedge pclk);
		psel   <= 1'b1;
		paddr  <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			bad("apb hang");
			results();
		end
	endtask

	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			if (qa.size() == 0)
				bad("unexpected apb answer");
			else
				cmp_bus(qa.pop_front());
		end
		if (hk_valid === 1'b1) begin
			if (qh.size() == 0)
				bad("unexpected word");
			else
				cmp_hk(qh.pop_front());
		end
	end

	task automatic half(input logic g, input int exp);
		logic v;
		int   n;
		for (int r = 0; r < 2; r++) begin
			v = g ? grav_exc : flip_exc;
			n = 0;
			while ((g ? grav_exc : flip_exc) === v && n < 300) begin
				@(posedge pclk);
				n++;
			end
		end
		cmp_pin(n, exp, "excitation half period");
	endtask

	initial begin
		#(100 * 50000);
		bad("watchdog");
		results();
	end

	//////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		cmd_s        c;
		logic [31:0] wd;
		logic [8:0]  d;
		logic [2:0]  g;
		int          k;
		seed = 32'hb0f00a03;
		{pclk, presetn, psel, penable, pwrite, conv_valid} = '0;
		{paddr, pwdata, det_pins, gimbal_open_pins, conv_data} = '0;
		{n_fail, n_checks} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		cmp_pin(subframe, SUB_LAST, "subframe after reset");
		for (int t = 0; t < NUM_ANALOG; t++) begin
			cmp_pin(conv_sel, t, "channel select");
			cmp_pin(therm_exc, t < NUM_THERM ? 5'(1) << t : 5'h0, "thermistor drive");
			ana[t] = 7'($random(seed));
			conv_data  <= ana[t];
			conv_valid <= 1'b1;
			@(posedge pclk);
			conv_valid <= 1'b0;
			repeat (3) @(posedge pclk);
		end
		$display("test converter done");
		apb(8'h0c, 1'b0, '0, {2'b01, 32'h0});
		apb(ADDR_STATUS, 1'b1, '1, {2'b01, 32'h0});
		apb(ADDR_HKWORD, 1'b1, '1, {2'b01, 32'h0});
		$display("test refusals done");
		for (int n = 0; n < 17; n++) begin
			wd = $random(seed);
			c  = cmd_s'(wd[CMD_W-1:0]);
			for (int a = 0; a < NUM_AXES; a++) begin
				k = $unsigned($random(seed)) % 4;
				d[3*a+:3] = (k == 3) ? 3'($random(seed)) : 3'h1 << k;
			end
			g = 3'($random(seed));
			det_pins         <= d;
			gimbal_open_pins <= g;
			apb(ADDR_CMD, 1'b1, wd, {2'b00, 32'h0});
			apb(ADDR_CMD, 1'b0, $random(seed), {2'b10, 14'h0, wd[17:0]});
			apb(ADDR_STATUS, 1'b0, '0, {2'b10, 19'h0, 4'((n + 15) % 16), g,
				fc(d[8:6]), fc(d[5:3]), fc(d[2:0])});
			k  = n % 16;
			lw = {ana[k % 8], flg(k, d, g, c), 1'b0};
			qh.push_back({4'(k), lw});
			fork
				host_u.run_frame();
				begin
					repeat (8) @(posedge pclk);
					det_pins         <= ~d;
					gimbal_open_pins <= ~g;
				end
			join
		end
		$display("test frames done");
		apb(ADDR_HKWORD, 1'b0, '0, {2'b10, 22'h0, lw});
		cmp_pin(last_word, lw, "host sampled word");
		cmp_pin(n_words, 17, "words presented");
		cmp_pin(qh.size(), 0, "words missing");
		half(1'b0, CLK_HZ / (2 * FLIP_EXC_HZ));
		half(1'b1, CLK_HZ / (2 * GRAV_EXC_HZ));
		$display("test excitation done");
		results();
	end
endmodule
